/* File: hw/serial_port_pkg.sv */
// Shared constants and types for the asynchronous serial port
`default_nettype none
package serial_port_pkg;
    localparam int DATA_W = 8;
    localparam int FIFO_DEPTH = 16;
    localparam int OSR_NORMAL = 16;
    localparam int OSR_FAST = 8;
    // Pulse length in counting ticks: 3/16 bit, or 3 low-power clocks
    localparam logic [2:0] IR_PULSE_TICKS = 3'h3;
    // Trigger level codes: 1/8, 1/4, 1/2, 3/4, 7/8 of depth
    localparam logic [2:0] TRIG_1_8 = 3'h0;
    localparam logic [2:0] TRIG_1_4 = 3'h1;
    localparam logic [2:0] TRIG_1_2 = 3'h2;
    localparam logic [2:0] TRIG_3_4 = 3'h3;
    localparam logic [2:0] TRIG_7_8 = 3'h4;
    // Interrupt source bit positions
    localparam int IRQ_RX = 0;
    localparam int IRQ_TX = 1;
    localparam int IRQ_MODEM = 2;
    localparam int IRQ_ERR = 3;
    localparam int IRQ_EOT = 4;
    localparam int IRQ_N = 5;
    // Pin filter reset: rxd idle high, infrared input idle low, cts_n high
    localparam logic [2:0] PIN_IDLE = 3'h5;
    typedef enum logic [2:0] {PAR_NONE, PAR_EVEN, PAR_ODD, PAR_STICK1, PAR_STICK0} parity_t;
endpackage
`default_nettype wire

/* File: hw/fifo_if.sv */
// Signal bundle between the port core and one character queue
`default_nettype none
interface fifo_if #(parameter int W = 8, parameter int D = 16);
    logic push;
    logic [W-1:0] wdata;
    logic pop;
    logic [W-1:0] rdata;
    logic [$clog2(D):0] count;
    logic full;
    logic empty;
    logic one_deep;
    modport user (output push, wdata, pop, one_deep, input rdata, count, full, empty);
    modport store (input push, wdata, pop, one_deep, output rdata, count, full, empty);
endinterface
`default_nettype wire

/* File: hw/sync_fifo.sv */
// Character queue with selectable one-entry depth
`default_nettype none
module sync_fifo #(
    parameter int W = 8,
    parameter int D = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    fifo_if.store f
);
    localparam int AW = $clog2(D);
    localparam int CW = AW + 1;
    logic [W-1:0] mem [D];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [CW-1:0] count_q;

    // Capacity and accepted strobes
    wire logic [CW-1:0] cap = f.one_deep ? CW'(1) : CW'(D);
    wire logic do_push = f.push && !f.full;
    wire logic do_pop = f.pop && !f.empty;
    assign f.full = (count_q >= cap);
    assign f.empty = (count_q == '0);
    assign f.count = count_q;
    assign f.rdata = mem[rd_q];

    // Storage array
    always_ff @(posedge clk) begin
        if (do_push) begin
            mem[wr_q] <= f.wdata;
        end
    end

    // Pointers and fill count
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_q <= '0;
            rd_q <= '0;
            count_q <= '0;
        end else begin
            wr_q <= wr_q + AW'(do_push);
            rd_q <= rd_q + AW'(do_pop);
            count_q <= count_q + CW'(do_push) - CW'(do_pop);
        end
    end

    property p_fifo_fill;
        @(posedge clk) disable iff (!rst_n)
        do_push && !do_pop |=> count_q == $past(count_q) + CW'(1);
    endproperty
    a_fifo_fill: assert property (p_fifo_fill) else $error("fifo count did not rise");
endmodule
`default_nettype wire

/* File: hw/infrared_serial_codec.sv */
// Infrared pulse encoder and decoder for the serial port
`default_nettype none
module infrared_serial_codec (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic tick,
    input wire logic enable,
    input wire logic low_power,
    input wire logic [7:0] lp_div,
    input wire logic bit_start,
    input wire logic tx_bit,
    input wire logic tx_busy,
    input wire logic ir_rx,
    output logic ir_tx,
    output logic rx_line
);
    import serial_port_pkg::*;
    logic [7:0] lp_cnt_q;
    logic [2:0] pcnt_q;
    logic [3:0] rcnt_q;
    logic ir_prev_q;
    logic rx_low_q;

    // Low-power clock divides by lp_div + 1
    wire logic lp_tick = (lp_cnt_q == lp_div);
    wire logic ptick = low_power ? lp_tick : tick;
    // Receive ignored while sending: half-duplex
    wire logic ir_edge = enable && ir_rx && !ir_prev_q && !tx_busy;
    assign rx_line = !rx_low_q;

    // Pulse generation and decoding
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lp_cnt_q <= '0;
            pcnt_q <= '0;
            rcnt_q <= '0;
            ir_prev_q <= 1'b0;
            rx_low_q <= 1'b0;
            ir_tx <= 1'b0;
        end else begin
            lp_cnt_q <= lp_tick ? 8'h00 : lp_cnt_q + 8'h01;
            ir_prev_q <= ir_rx;
            if (enable && bit_start && !tx_bit) begin
                ir_tx <= 1'b1;
                pcnt_q <= '0;
            end else if (ir_tx && ptick) begin
                if (pcnt_q == IR_PULSE_TICKS - 3'h1) begin
                    ir_tx <= 1'b0;
                end
                pcnt_q <= pcnt_q + 3'h1;
            end
            if (ir_edge) begin
                rx_low_q <= 1'b1;
                rcnt_q <= '0;
            end else if (rx_low_q && tick) begin
                if (rcnt_q == 4'(OSR_NORMAL - 1)) begin
                    rx_low_q <= 1'b0;
                end
                rcnt_q <= rcnt_q + 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

/* File: hw/async_serial_port.sv */
// Asynchronous serial port top: baud timing, framing, queues, status and requests
`default_nettype none
// Summary of operation
// - Bit time is 16 oversampling ticks, or 8 in high-speed mode when infrared mode is off.
// - Separate transmit and receive queues, sixteen eight-bit entries each.
// - Queues can be set to one entry, acting as a double buffer.
// - Level thresholds selectable at 1/8, 1/4, 1/2, 3/4 or 7/8 of depth.
// - Characters carry five to eight data bits after a start bit.
// - Parity even, odd, stick or none, generated and checked.
// - Transmitter sends one or two stop bits as configured.
// - A start bit not still low at mid-check is dropped as false.
// - Break is forced on the plain line on command, except in infrared mode, and detected on receive.
// - Receive, transmit, modem and error sources are individually maskable.
// - One interrupt output is high while any source is pending and unmasked.
// - End-of-transmission source fires once all queued data is sent.
// - Receive single request while data queued; burst at the set level.
// - Transmit single request while space remains; burst at the set level.
// - Infrared codec replaces plain line, half-duplex, up to 115.2 Kbps.
// - Infrared pulse lasts 3/16 bit, or fixed low-power length.
// - Low-power pulse clock divides the reference by 1 to 256.
module async_serial_port #(
    parameter int BAUD_W = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [BAUD_W-1:0] baud_div,
    input wire logic high_speed,
    input wire logic fifo_en,
    input wire logic [1:0] data_bits,
    input wire serial_port_pkg::parity_t parity_mode,
    input wire logic two_stop,
    input wire logic send_break,
    input wire logic [2:0] tx_trig,
    input wire logic [2:0] rx_trig,
    input wire logic ir_en,
    input wire logic ir_low_power,
    input wire logic [7:0] ir_lp_div,
    input wire logic [serial_port_pkg::DATA_W-1:0] tx_data,
    input wire logic tx_wr,
    output logic tx_full,
    output logic [serial_port_pkg::DATA_W-1:0] rx_data,
    input wire logic rx_rd,
    output logic rx_empty,
    output logic frame_err,
    output logic parity_err,
    output logic break_err,
    output logic overrun_err,
    input wire logic err_clr,
    input wire logic [serial_port_pkg::IRQ_N-1:0] int_mask,
    input wire logic [serial_port_pkg::IRQ_N-1:0] int_clr,
    output logic [serial_port_pkg::IRQ_N-1:0] int_status,
    output logic int_out,
    output logic rx_dma_single,
    output logic rx_dma_burst,
    output logic tx_dma_single,
    output logic tx_dma_burst,
    input wire logic rxd,
    output logic txd,
    input wire logic ir_rx,
    output logic ir_tx,
    input wire logic cts_n
);
    import serial_port_pkg::*;
    localparam int CW = $clog2(FIFO_DEPTH) + 1;
    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} tx_state_t;
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_HOLD} rx_state_t;

    //--------------------------------------------------------------
    // Reset release and pin filtering
    //--------------------------------------------------------------
    logic rst_q1;
    logic rst_sync_n;
    logic [2:0] pin_s1_q;
    logic [2:0] pin_s2_q;
    logic [2:0] pin_s3_q;
    logic [2:0] pin_f_q;

    // Reset released through two flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_q1 <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_q1 <= 1'b1;
            rst_sync_n <= rst_q1;
        end
    end

    // Three-stage capture; a level counts once stages two and three agree
    wire logic [2:0] pin_agree = ~(pin_s2_q ^ pin_s3_q);
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pin_s1_q <= PIN_IDLE;
            pin_s2_q <= PIN_IDLE;
            pin_s3_q <= PIN_IDLE;
            pin_f_q <= PIN_IDLE;
        end else begin
            pin_s1_q <= {cts_n, ir_rx, rxd};
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
            pin_f_q <= (pin_s2_q & pin_agree) | (pin_f_q & ~pin_agree);
        end
    end

    //--------------------------------------------------------------
    // Baud ticks and character format
    //--------------------------------------------------------------
    logic [BAUD_W-1:0] baud_cnt_q;
    wire logic tick = (baud_cnt_q == baud_div);
    // Infrared operation always uses the x16 rate
    wire logic [4:0] osr = (high_speed && !ir_en) ? 5'(OSR_FAST) : 5'(OSR_NORMAL);
    wire logic [4:0] last_ph = osr - 5'h1;
    wire logic [4:0] half_m1 = {1'b0, osr[4:1]} - 5'h1;
    wire logic [2:0] nbits_m1 = {1'b1, data_bits};
    wire logic [7:0] dmask = 8'hFF >> (2'h3 - data_bits);
    wire logic par_on = (parity_mode != PAR_NONE);

    // Parity value for a masked character
    function automatic logic par_bit(input parity_t m, input logic [7:0] d);
        case (m)
            PAR_EVEN: par_bit = ^d;
            PAR_ODD: par_bit = ~^d;
            PAR_STICK1: par_bit = 1'b1;
            default: par_bit = 1'b0;
        endcase
    endfunction

    // Threshold count for a trigger code at the active depth
    function automatic logic [CW-1:0] trig_level(input logic [2:0] code, input logic one);
        int num;
        int lvl;
        case (code)
            TRIG_1_8: num = 1;
            TRIG_1_4: num = 2;
            TRIG_3_4: num = 6;
            TRIG_7_8: num = 7;
            default: num = 4;
        endcase
        lvl = ((one ? 1 : FIFO_DEPTH) * num) / 8;
        trig_level = CW'(lvl);
    endfunction

    // Free-running oversample divider
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            baud_cnt_q <= '0;
        end else begin
            baud_cnt_q <= tick ? '0 : baud_cnt_q + BAUD_W'(1);
        end
    end

    //--------------------------------------------------------------
    // Queues
    //--------------------------------------------------------------
    fifo_if #(.W(DATA_W), .D(FIFO_DEPTH)) txf ();
    fifo_if #(.W(DATA_W), .D(FIFO_DEPTH)) rxf ();
    logic rx_push_q;
    logic [7:0] rsh_q;
    wire logic tx_pop;

    sync_fifo #(.W(DATA_W), .D(FIFO_DEPTH)) u_tx_fifo (
        .clk(clk),
        .rst_n(rst_sync_n),
        .f(txf)
    );
    sync_fifo #(.W(DATA_W), .D(FIFO_DEPTH)) u_rx_fifo (
        .clk(clk),
        .rst_n(rst_sync_n),
        .f(rxf)
    );

    // Queue hookup and level requests
    wire logic [CW-1:0] tx_thr = trig_level(tx_trig, !fifo_en);
    wire logic [CW-1:0] rx_lvl = trig_level(rx_trig, !fifo_en);
    wire logic [CW-1:0] rx_thr = (rx_lvl == '0) ? CW'(1) : rx_lvl;
    assign txf.push = tx_wr;
    assign txf.wdata = tx_data;
    assign txf.pop = tx_pop;
    assign txf.one_deep = !fifo_en;
    assign rxf.push = rx_push_q;
    assign rxf.wdata = rsh_q;
    assign rxf.pop = rx_rd;
    assign rxf.one_deep = !fifo_en;
    assign tx_full = txf.full;
    assign rx_empty = rxf.empty;
    assign rx_data = rxf.rdata;
    assign rx_dma_single = !rxf.empty;
    assign rx_dma_burst = (rxf.count >= rx_thr);
    assign tx_dma_single = !txf.full;
    assign tx_dma_burst = (txf.count <= tx_thr);

    //--------------------------------------------------------------
    // Transmitter
    //--------------------------------------------------------------
    tx_state_t tx_st_q;
    logic [4:0] tph_q;
    logic [2:0] tbit_q;
    logic [7:0] tsh_q;
    logic tpar_q;
    logic tstop_q;
    logic tx_bit_q;
    logic bit_start_q;
    logic tx_done_q;
    wire logic tend = tick && (tph_q == last_ph);
    assign tx_pop = (tx_st_q == TX_IDLE) && !txf.empty && !send_break;

    // Framing sequencer
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            tx_st_q <= TX_IDLE;
            tph_q <= '0;
            tbit_q <= '0;
            tsh_q <= '0;
            tpar_q <= 1'b0;
            tstop_q <= 1'b0;
            tx_bit_q <= 1'b1;
            bit_start_q <= 1'b0;
            tx_done_q <= 1'b0;
        end else begin
            bit_start_q <= tend && (tx_st_q != TX_IDLE);
            tx_done_q <= 1'b0;
            if (tick) begin
                tph_q <= tend ? 5'h00 : tph_q + 5'h01;
            end
            case (tx_st_q)
                TX_IDLE: if (tx_pop) begin
                    tx_st_q <= TX_START;
                    tph_q <= '0;
                    tbit_q <= '0;
                    tsh_q <= txf.rdata;
                    tpar_q <= par_bit(parity_mode, txf.rdata & dmask);
                    tx_bit_q <= 1'b0;
                    bit_start_q <= 1'b1;
                end
                TX_START: if (tend) begin
                    tx_st_q <= TX_DATA;
                    tx_bit_q <= tsh_q[0];
                    tsh_q <= tsh_q >> 1;
                end
                TX_DATA: if (tend) begin
                    if (tbit_q == nbits_m1) begin
                        tx_st_q <= par_on ? TX_PAR : TX_STOP;
                        tx_bit_q <= par_on ? tpar_q : 1'b1;
                        tstop_q <= 1'b0;
                    end else begin
                        tbit_q <= tbit_q + 3'h1;
                        tx_bit_q <= tsh_q[0];
                        tsh_q <= tsh_q >> 1;
                    end
                end
                TX_PAR: if (tend) begin
                    tx_st_q <= TX_STOP;
                    tx_bit_q <= 1'b1;
                    tstop_q <= 1'b0;
                end
                TX_STOP: if (tend) begin
                    if (two_stop && !tstop_q) begin
                        tstop_q <= 1'b1;
                    end else begin
                        tx_st_q <= TX_IDLE;
                        tx_done_q <= txf.empty;
                    end
                end
                default: tx_st_q <= TX_IDLE;
            endcase
        end
    end

    // Line driver; infrared mode parks the plain line high
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            txd <= 1'b1;
        end else begin
            txd <= ir_en || (!send_break && tx_bit_q);
        end
    end

    //--------------------------------------------------------------
    // Infrared codec
    //--------------------------------------------------------------
    logic ir_line;
    infrared_serial_codec u_ir (
        .clk(clk),
        .rst_n(rst_sync_n),
        .tick(tick),
        .enable(ir_en),
        .low_power(ir_low_power),
        .lp_div(ir_lp_div),
        .bit_start(bit_start_q),
        .tx_bit(tx_bit_q && !send_break),
        .tx_busy(tx_st_q != TX_IDLE),
        .ir_rx(pin_f_q[1]),
        .ir_tx(ir_tx),
        .rx_line(ir_line)
    );

    //--------------------------------------------------------------
    // Receiver
    //--------------------------------------------------------------
    rx_state_t rx_st_q;
    logic [4:0] rph_q;
    logic [2:0] rbit_q;
    logic rpar_q;
    logic [2:0] rerr_q;
    wire logic line = ir_en ? ir_line : pin_f_q[0];
    wire logic rend = tick && (rph_q == last_ph);
    wire logic rmid = tick && (rph_q == half_m1);
    wire logic par_bad = par_on && (rpar_q != par_bit(parity_mode, rsh_q & dmask));

    // Character assembly
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            rx_st_q <= RX_IDLE;
            rph_q <= '0;
            rbit_q <= '0;
            rsh_q <= '0;
            rpar_q <= 1'b0;
            rerr_q <= '0;
            rx_push_q <= 1'b0;
        end else begin
            rx_push_q <= 1'b0;
            rerr_q <= '0;
            if (tick) begin
                rph_q <= rend ? 5'h00 : rph_q + 5'h01;
            end
            case (rx_st_q)
                RX_IDLE: if (!line) begin
                    rx_st_q <= RX_START;
                    rph_q <= '0;
                    rbit_q <= '0;
                    rsh_q <= '0;
                    rpar_q <= 1'b0;
                end
                RX_START: if (rmid) begin
                    rph_q <= '0;
                    rx_st_q <= line ? RX_IDLE : RX_DATA;
                end
                RX_DATA: if (rend) begin
                    rsh_q[rbit_q] <= line;
                    if (rbit_q == nbits_m1) begin
                        rx_st_q <= par_on ? RX_PAR : RX_STOP;
                    end else begin
                        rbit_q <= rbit_q + 3'h1;
                    end
                end
                RX_PAR: if (rend) begin
                    rpar_q <= line;
                    rx_st_q <= RX_STOP;
                end
                RX_STOP: if (rend) begin
                    rx_push_q <= 1'b1;
                    rerr_q[0] <= !line;
                    rerr_q[1] <= par_bad;
                    rerr_q[2] <= !line && (rsh_q == 8'h00) && !rpar_q;
                    rx_st_q <= line ? RX_IDLE : RX_HOLD;
                end
                RX_HOLD: if (line) begin
                    rx_st_q <= RX_IDLE;
                end
                default: rx_st_q <= RX_IDLE;
            endcase
        end
    end

    //--------------------------------------------------------------
    // Error flags and interrupt sources
    //--------------------------------------------------------------
    logic [3:0] err_q;
    logic cts_prev_q;
    logic [IRQ_N-1:0] pend_q;
    wire logic [3:0] err_set = {rx_push_q && rxf.full, rerr_q};
    wire logic [IRQ_N-1:0] irq_ev;
    assign irq_ev[IRQ_RX] = rx_dma_burst;
    assign irq_ev[IRQ_TX] = tx_dma_burst;
    assign irq_ev[IRQ_MODEM] = (pin_f_q[2] != cts_prev_q);
    assign irq_ev[IRQ_ERR] = |err_set;
    assign irq_ev[IRQ_EOT] = tx_done_q;
    assign {overrun_err, break_err, parity_err, frame_err} = err_q;
    assign int_status = pend_q;
    assign int_out = |(pend_q & int_mask);

    // Sticky flags; a new event beats a clear in the same cycle
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            err_q <= '0;
            cts_prev_q <= 1'b1;
            pend_q <= '0;
        end else begin
            err_q <= err_set | (err_q & ~{4{err_clr}});
            cts_prev_q <= pin_f_q[2];
            pend_q <= irq_ev | (pend_q & ~int_clr);
        end
    end

    //--------------------------------------------------------------
    // Checks
    //--------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_sync_n);

    property p_rx_single;
        rx_push_q && rx_empty && !rx_rd |=> rx_dma_single;
    endproperty
    a_rx_single: assert property (p_rx_single) else $error("no rx single request");
    property p_tx_single;
        tx_pop && !tx_wr |=> tx_dma_single;
    endproperty
    a_tx_single: assert property (p_tx_single) else $error("no tx single request");
    property p_err_int;
        irq_ev[IRQ_ERR] && int_mask[IRQ_ERR] |=> int_out && int_status[IRQ_ERR];
    endproperty
    a_err_int: assert property (p_err_int) else $error("error did not interrupt");
    property p_eot;
        tx_done_q |=> int_status[IRQ_EOT] && tx_st_q != TX_STOP;
    endproperty
    a_eot: assert property (p_eot) else $error("end of transmission lost");
    property p_break;
        send_break && !ir_en |=> !txd;
    endproperty
    a_break: assert property (p_break) else $error("break not driven");
    property p_false_start;
        rx_st_q == RX_START && rmid && line |=> rx_st_q == RX_IDLE ##1 !rx_push_q;
    endproperty
    a_false_start: assert property (p_false_start) else $error("false start kept");
    property p_two_stop;
        tx_st_q == TX_STOP && tend && two_stop && !tstop_q |=> tx_st_q == TX_STOP && tx_bit_q;
    endproperty
    a_two_stop: assert property (p_two_stop) else $error("second stop bit missing");
    property p_data_len;
        rx_st_q == RX_DATA && rend && rbit_q == nbits_m1 && !par_on |=> rx_st_q == RX_STOP;
    endproperty
    a_data_len: assert property (p_data_len) else $error("wrong data bit count");
endmodule
`default_nettype wire

/* File: verification/remote_serial_device.sv */
// Remote serial device: frames characters onto rxd and decodes txd
`default_nettype none
module remote_serial_device #(
    parameter int BIT = 32
) (
    input wire logic clk,
    input wire logic txd,
    output logic rxd
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] got[$];
    logic [7:0] sh;
    // Line idles high between frames
    initial rxd = 1'b1;
    // Ten line bits LSB first, each n cycles long
    task automatic send(input logic [9:0] f, input int n);
        for (int i = 0; i < 10; i++) begin
            @(posedge clk);
            #1 rxd = f[i];
            repeat (n - 1) @(posedge clk);
        end
    endtask
    // Sample txd at bit centres after each falling edge
    always begin
        @(negedge txd);
        repeat (BIT / 2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT) @(posedge clk);
            sh[i] = txd;
        end
        repeat (BIT) @(posedge clk);
        got.push_back(txd === 1'b1 ? sh : 8'hXX);
    end
endmodule
`default_nettype wire

/* File: verification/test_async_serial_port.sv */
// Testbench of the serial port with a queue model and a remote device
`default_nettype none
module test_async_serial_port;
    timeunit 1ns;
    timeprecision 1ps;
    import serial_port_pkg::*;
    localparam int BIT = OSR_NORMAL * 2;
    logic clk = 1'b0, rst_n = 1'b0, high_speed = 1'b0, fifo_en = 1'b1, two_stop = 1'b1;
    logic send_break = 1'b0, ir_en = 1'b0, ir_low_power = 1'b0, tx_wr = 1'b0, rx_rd = 1'b0;
    logic err_clr = 1'b0, ir_rx = 1'b0, cts_n = 1'b1;
    logic [15:0] baud_div = 16'h0001;
    logic [1:0] data_bits = 2'h3;
    parity_t parity_mode = PAR_NONE;
    logic [2:0] tx_trig = TRIG_1_2, rx_trig = TRIG_1_8;
    logic [7:0] ir_lp_div = 8'h00, tx_data = 8'h00, rx_data;
    logic [4:0] int_mask = 5'h10, int_clr = 5'h00, int_status;
    logic tx_full, rx_empty, frame_err, parity_err, break_err, overrun_err, int_out;
    logic rx_dma_single, rx_dma_burst, tx_dma_single, tx_dma_burst, rxd, txd, ir_tx;
    int failures = 0, checks_done = 0;
    logic [31:0] seed = 32'h902F;
    logic [7:0] exp_q[$];
    always #5 clk = ~clk;
    async_serial_port async_serial_port_inst (.clk, .rst_n, .baud_div, .high_speed, .fifo_en,
        .data_bits, .parity_mode, .two_stop, .send_break, .tx_trig, .rx_trig, .ir_en,
        .ir_low_power, .ir_lp_div, .tx_data, .tx_wr, .tx_full, .rx_data, .rx_rd, .rx_empty,
        .frame_err, .parity_err, .break_err, .overrun_err, .err_clr, .int_mask, .int_clr,
        .int_status, .int_out, .rx_dma_single, .rx_dma_burst, .tx_dma_single, .tx_dma_burst,
        .rxd, .txd, .ir_rx, .ir_tx, .cts_n);
    remote_serial_device #(.BIT(BIT)) remote_serial_device_inst (.clk, .txd, .rxd);
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] r;
        r = s ^ (s << 13);
        r = r ^ (r >> 17);
        return r ^ (r << 5);
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        checks_done++;
        if (seen !== want) begin
            failures++;
            $display("BAD %0t: saw %h want %h", $time, seen, want);
        end
    endtask
    task automatic end_of_test;
        if (failures == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Watchdog against a hung handshake
    initial begin
        #300000;
        failures++;
        end_of_test;
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        cyc(3);
        rst_n = 1'b1;
        cyc(3);
        check({2'h0, txd, rx_empty, tx_full, tx_dma_single, rx_dma_single, int_out}, 8'h34);
        for (int i = 0; i < 3; i++) begin
            seed = xs(seed);
            exp_q.push_back(seed[7:0]);
            tx_data = seed[7:0];
            tx_wr = 1'b1;
            cyc(1);
        end
        tx_wr = 1'b0;
        for (int n = 0; n < 3000 && remote_serial_device_inst.got.size() < 3; n++) cyc(1);
        cyc(60);
        check(8'(remote_serial_device_inst.got.size()), 8'h03);
        while (exp_q.size() > 0) check(remote_serial_device_inst.got.pop_front(), exp_q.pop_front());
        check({7'h00, int_out}, 8'h01);
        int_mask = 5'h00;
        cyc(1);
        check({7'h00, int_out}, 8'h00);
        int_clr = 5'h1F;
        cyc(1);
        int_clr = 5'h00;
        cyc(1);
        check({7'h00, int_status[IRQ_EOT]}, 8'h00);
        remote_serial_device_inst.send(10'h3FE, 8);
        cyc(100);
        check({7'h00, rx_empty}, 8'h01);
        for (int i = 0; i < 2; i++) begin
            seed = xs(seed);
            exp_q.push_back(seed[7:0]);
            remote_serial_device_inst.send({1'b1, seed[7:0], 1'b0}, BIT);
        end
        cyc(10);
        check({6'h00, rx_dma_single, rx_dma_burst}, 8'h03);
        while (exp_q.size() > 0) begin
            check(rx_data, exp_q.pop_front());
            rx_rd = 1'b1;
            cyc(1);
        end
        rx_rd = 1'b0;
        check({7'h00, rx_empty}, 8'h01);
        // Break in, then a fast seven-bit character with a bad even parity bit
        int_mask = 5'h08;
        remote_serial_device_inst.send(10'h000, BIT);
        remote_serial_device_inst.send(10'h3FF, 1);
        cyc(10);
        check({4'h0, overrun_err, break_err, parity_err, frame_err}, 8'h05);
        check({6'h00, int_out, int_status[IRQ_ERR]}, 8'h03);
        check(rx_data, 8'h00);
        rx_rd = 1'b1;
        err_clr = 1'b1;
        high_speed = 1'b1;
        data_bits = 2'h2;
        parity_mode = PAR_EVEN;
        cyc(1);
        rx_rd = 1'b0;
        err_clr = 1'b0;
        seed = xs(seed);
        remote_serial_device_inst.send({1'b1, ~^seed[6:0], seed[6:0], 1'b0}, OSR_FAST * 2);
        cyc(10);
        check({4'h0, overrun_err, break_err, parity_err, frame_err}, 8'h02);
        check(rx_data, {1'b0, seed[6:0]});
        // Queue levels while a held break keeps the transmitter idle
        send_break = 1'b1;
        fifo_en = 1'b0;
        tx_wr = 1'b1;
        cyc(1);
        check({5'h00, tx_full, tx_dma_single, tx_dma_burst}, 8'h04);
        check({7'h00, txd}, 8'h00);
        fifo_en = 1'b1;
        for (int i = 1; i < 16; i++) begin
            cyc(1);
            if (i == 8) check({5'h00, tx_full, tx_dma_single, tx_dma_burst}, 8'h02);
        end
        tx_wr = 1'b0;
        check({5'h00, tx_full, tx_dma_single, tx_dma_burst}, 8'h04);
        // Infrared pulse at the start bit once the break is lifted
        ir_en = 1'b1;
        send_break = 1'b0;
        cyc(6);
        check({6'h00, txd, ir_tx}, 8'h03);
        cyc(2);
        check({7'h00, ir_tx}, 8'h00);
        end_of_test;
    end
endmodule
`default_nettype wire
